//--- rtl/owct_defines.svh
// option word bit positions, reset values and timing counts
`ifndef OWCT_DEFINES_SVH
`define OWCT_DEFINES_SVH
// ----------------------------------------
// option word layout
// ----------------------------------------
`define OWCT_CFG_W 13
`define OWCT_B_OSC_TYPE 12
`define OWCT_B_WDT_DIS 11
`define OWCT_B_CYCLE_CLOCKS_SEL 10
`define OWCT_B_PROT_N 9
`define OWCT_B_XFREQ 8
`define OWCT_B_RC_SRC 7
`define OWCT_B_PWR 6
`define OWCT_B_DLY0 5
`define OWCT_B_DLY1 4
`define OWCT_ID_MSB 3
`define OWCT_ID_LSB 0
`define OWCT_CFG_RST 13'h1FFF
// ----------------------------------------
// timing
// ----------------------------------------
`define OWCT_CLK_MHZ 40
`define OWCT_DLY50_NS 50
`define OWCT_DLY100_NS 100
`define OWCT_DLY50_CYC ((`OWCT_DLY50_NS * `OWCT_CLK_MHZ) / 1000)
`define OWCT_DLY100_CYC ((`OWCT_DLY100_NS * `OWCT_CLK_MHZ) / 1000)
`define OWCT_PH_LAST2 2'h1
`define OWCT_PH_LAST4 2'h3
// ----------------------------------------
// instruction decode constants
// ----------------------------------------
`define OWCT_PC_REG 6'h02
`define OWCT_IO_TOP 6'h0F
`define OWCT_OP_RET 13'h0012
`define OWCT_OP_RETURN_FROM_INTERRUPT 13'h0013
`define OWCT_OP_TBL 13'h0020
`define OWCT_BANK_MSB 7
`define OWCT_BANK_LSB 6
`endif

//--- rtl/owct_operand_decode.sv
// operand field decoder: register designator, bank, bit and literal fields
`timescale 1ns/100ps
`default_nettype none
`include "owct_defines.svh"
module owct_operand_decode #(
  parameter int BIT_FIELD_LSB = 6
) (
  owct_operand_if.dec op
);
  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  wire [5:0] reg_field = op.instr[5:0];
  wire [2:0] bit_field = op.instr[BIT_FIELD_LSB +: 3];
  // bank bits extend the 6-bit designator into a full address
  assign op.addr = {op.bank, reg_field};
  // i/o and general registers share one designator field
  assign op.is_io = (reg_field <= `OWCT_IO_TOP);
  assign op.is_pc_dest = (reg_field == `OWCT_PC_REG);
  assign op.bit_mask = 8'h01 << bit_field;
  // literal fields, both taken from the low end of the word
  assign op.lit8 = op.instr[7:0];
  assign op.lit10 = op.instr[9:0];
endmodule
`default_nettype wire

//--- rtl/owct_operand_if.sv
// operand bundle between the timing core and the operand decoder
`timescale 1ns/100ps
`default_nettype none
interface owct_operand_if;
  logic [12:0] instr;
  logic [1:0] bank;
  logic [7:0] addr;
  logic [7:0] bit_mask;
  logic is_io;
  logic is_pc_dest;
  logic [7:0] lit8;
  logic [9:0] lit10;
  modport dec (input instr, bank, output addr, bit_mask, is_io, is_pc_dest, lit8, lit10);
  modport core (output instr, bank, input addr, bit_mask, is_io, is_pc_dest, lit8, lit10);
endinterface
`default_nettype wire

//--- rtl/owct_option_timing.sv
// option word loader and instruction cycle timing core
`timescale 1ns/100ps
`default_nettype none
`include "owct_defines.svh"
// Behaviour
// - bit 12: 0 rc oscillator, 1 crystal
// - bit 11: 0 enables watchdog, 1 disables
// - bit 10: two or four clocks per cycle
// - bit 9 low enables code protection
// - bit 8 selects low/high crystal range
// - bit 7: internal c or external rc
// - bit 6: low or high oscillator power
// - delay bits pick 0, 50, 100 ns
// - bits 3..0 are inert user id
// - instructions are one 13-bit word
// - normal instruction takes one instruction cycle
// - pc writes, flow changes, taken skips: two
// - any register bit set, clear, test
// - i/o registers addressed like general ones
// - pointer bits 7:6 select register bank
// - literals are 8 or 10 bits
module owct_option_timing
  import owct_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [12:0] cfg_word_i,
  input wire logic [12:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic flow_change_i,
  input wire logic skip_true_i,
  input wire owct_bitop_t bit_op_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic [7:0] rsp_i,
  input wire logic serial_data_in_i,
  output logic osc_is_xtal_o,
  output logic osc_ext_rc_o,
  output logic osc_int_c_ext_r_o,
  output logic high_crystal_mode_o,
  output logic low_crystal_mode_o,
  output logic osc_high_power_o,
  output logic wdt_enable_o,
  output logic four_clk_cycle_o,
  output logic code_protect_o,
  output logic [1:0] sdi_delay_sel_o,
  output logic [3:0] user_id_o,
  output logic cfg_conflict_o,
  output logic cycle_strobe_o,
  output logic instr_accept_o,
  output logic instr_done_o,
  output logic two_cycle_o,
  output logic [7:0] reg_addr_o,
  output logic reg_is_io_o,
  output logic reg_we_o,
  output logic [7:0] reg_wdata_o,
  output logic bit_test_o,
  output logic [7:0] lit8_o,
  output logic [9:0] lit10_o,
  output logic serial_data_dly_o
);
  // ----------------------------------------
  // option word capture
  // ----------------------------------------
  logic [12:0] cfg;
  // word is sampled while reset is held and frozen after release
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cfg <= cfg_word_i;
    end
  end

  // ----------------------------------------
  // option decode
  // ----------------------------------------
  wire is_xtal = cfg[`OWCT_B_OSC_TYPE];
  wire xfreq = cfg[`OWCT_B_XFREQ];
  wire hi_pwr = cfg[`OWCT_B_PWR];
  // rc source only counts when rc type is chosen
  wire ext_rc = !is_xtal && cfg[`OWCT_B_RC_SRC];
  wire int_c = !is_xtal && !cfg[`OWCT_B_RC_SRC];
  wire high_crystal_mode = is_xtal && xfreq;
  wire low_crystal_mode = is_xtal && !xfreq && !hi_pwr;
  // flags words the programmer should never write
  wire conflict = (!is_xtal && xfreq) || (is_xtal && !xfreq && hi_pwr);
  wire four = cfg[`OWCT_B_CYCLE_CLOCKS_SEL];
  wire [1:0] dly_sel = {cfg[`OWCT_B_DLY1], cfg[`OWCT_B_DLY0]};

  // decoded options refresh every edge from the frozen word
  always_ff @(posedge clk_i) begin
    osc_is_xtal_o <= is_xtal;
    osc_ext_rc_o <= ext_rc;
    osc_int_c_ext_r_o <= int_c;
    high_crystal_mode_o <= high_crystal_mode;
    low_crystal_mode_o <= low_crystal_mode;
    osc_high_power_o <= hi_pwr;
    wdt_enable_o <= !cfg[`OWCT_B_WDT_DIS];
    four_clk_cycle_o <= four;
    code_protect_o <= !cfg[`OWCT_B_PROT_N];
    sdi_delay_sel_o <= dly_sel;
    user_id_o <= cfg[`OWCT_ID_MSB:`OWCT_ID_LSB];
    cfg_conflict_o <= conflict;
  end

  // ----------------------------------------
  // serial input synchroniser and delay
  // ----------------------------------------
  logic sdi_s1;
  logic sdi_s2;
  logic sdi_s3;
  logic sdi_filt;
  logic [3:0] sdi_line;
  // a change counts only once stages two and three agree
  wire next_sdi_filt = (sdi_s2 == sdi_s3) ? sdi_s2 : sdi_filt;
  // unlisted code 00 falls back to no delay
  wire sdi_tap = (dly_sel == 2'h1) ? sdi_line[`OWCT_DLY50_CYC - 1] :
                 (dly_sel == 2'h2) ? sdi_line[`OWCT_DLY100_CYC - 1] : sdi_filt;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sdi_s1 <= 1'h0;
      sdi_s2 <= 1'h0;
      sdi_s3 <= 1'h0;
      sdi_filt <= 1'h0;
      sdi_line <= 4'h0;
      serial_data_dly_o <= 1'h0;
    end else begin
      sdi_s1 <= serial_data_in_i;
      sdi_s2 <= sdi_s1;
      sdi_s3 <= sdi_s2;
      sdi_filt <= next_sdi_filt;
      sdi_line <= {sdi_line[2:0], sdi_filt};
      serial_data_dly_o <= sdi_tap;
    end
  end

  // ----------------------------------------
  // instruction cycle phase
  // ----------------------------------------
  logic [1:0] ph;
  // the oscillator clock is clk_i; one cycle is 2 or 4 of them
  wire cyc_last = (ph == (four ? `OWCT_PH_LAST4 : `OWCT_PH_LAST2));
  wire [1:0] next_ph = cyc_last ? 2'h0 : ph + 2'h1;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ph <= 2'h0;
      cycle_strobe_o <= 1'h0;
    end else begin
      ph <= next_ph;
      cycle_strobe_o <= cyc_last;
    end
  end

  // ----------------------------------------
  // operand decode
  // ----------------------------------------
  owct_operand_if op_bus ();
  assign op_bus.instr = instr_i;
  assign op_bus.bank = rsp_i[`OWCT_BANK_MSB:`OWCT_BANK_LSB];
  owct_operand_decode #(
    .BIT_FIELD_LSB(6)
  ) u_dec (
    .op(op_bus)
  );

  // ----------------------------------------
  // execution sequencing
  // ----------------------------------------
  owct_exec_t state;
  owct_exec_t next_state;
  owct_bitop_t bop;
  logic [7:0] mask;
  logic pc_change;
  // register destination ops: top bits clear, bit 6 set, nonzero group
  wire dest_r = (instr_i[12:10] == 3'h0) && instr_i[6] && (instr_i[9:6] != 4'h1 ||
                instr_i[6]);
  wire writes_pc = dest_r && op_bus.is_pc_dest && (instr_i[12:6] != 7'h00);
  wire fixed_flow = (instr_i == `OWCT_OP_RET) || (instr_i == `OWCT_OP_RETURN_FROM_INTERRUPT) ||
                    (instr_i == `OWCT_OP_TBL);
  wire first_end = cyc_last && (state == EX_ONE);
  // second cycle when the pc moves or a skip tests true
  wire need_two = pc_change || skip_true_i;
  wire finish = cyc_last && ((state == EX_ONE && !need_two) || state == EX_TWO);
  wire take = cyc_last && instr_valid_i && (state == EX_IDLE || finish);
  wire bit_wr = first_end && (bop == BOP_SET || bop == BOP_CLR);
  wire [7:0] set_val = reg_rdata_i | mask;
  wire [7:0] clr_val = reg_rdata_i & ~mask;

  // state choice kept combinational so the flops below stay short
  always_comb begin
    next_state = state;
    case (state)
      EX_IDLE: begin
        if (take) begin
          next_state = EX_ONE;
        end
      end
      EX_ONE: begin
        if (cyc_last) begin
          next_state = need_two ? EX_TWO : (take ? EX_ONE : EX_IDLE);
        end
      end
      EX_TWO: begin
        if (cyc_last) begin
          next_state = take ? EX_ONE : EX_IDLE;
        end
      end
      default: begin
        next_state = EX_IDLE;
      end
    endcase
  end

  // instruction capture on the boundary it is taken
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      bop <= BOP_NONE;
      mask <= 8'h00;
      pc_change <= 1'h0;
      reg_addr_o <= 8'h00;
      reg_is_io_o <= 1'h0;
      lit8_o <= 8'h00;
      lit10_o <= 10'h000;
    end else if (take) begin
      bop <= bit_op_i;
      mask <= op_bus.bit_mask;
      pc_change <= writes_pc || fixed_flow || flow_change_i;
      reg_addr_o <= op_bus.addr;
      reg_is_io_o <= op_bus.is_io;
      lit8_o <= op_bus.lit8;
      lit10_o <= op_bus.lit10;
    end
  end

  // sequencing flags and bit operation results
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state <= EX_IDLE;
      instr_accept_o <= 1'h0;
      instr_done_o <= 1'h0;
      two_cycle_o <= 1'h0;
      reg_we_o <= 1'h0;
      reg_wdata_o <= 8'h00;
      bit_test_o <= 1'h0;
    end else begin
      state <= next_state;
      instr_accept_o <= take;
      instr_done_o <= finish;
      two_cycle_o <= (next_state == EX_TWO);
      reg_we_o <= bit_wr;
      if (bit_wr) begin
        reg_wdata_o <= (bop == BOP_SET) ? set_val : clr_val;
      end
      if (first_end && bop == BOP_TEST) begin
        bit_test_o <= |(reg_rdata_i & mask);
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_cfg_held;
    @(posedge clk_i) disable iff (!resetn_i)
      $past(resetn_i) |-> $stable(cfg);
  endproperty
  a_cfg_held: assert property (p_cfg_held) else $error("option word moved");

  property p_osc_type;
    @(posedge clk_i) disable iff (!resetn_i)
      $past(resetn_i) |-> osc_is_xtal_o == $past(cfg[`OWCT_B_OSC_TYPE]);
  endproperty
  a_osc_type: assert property (p_osc_type) else $error("osc type wrong");

  property p_wdt;
    @(posedge clk_i) disable iff (!resetn_i)
      $past(resetn_i) |-> wdt_enable_o != $past(cfg[`OWCT_B_WDT_DIS]);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog enable inverted");

  property p_four_clk;
    @(posedge clk_i) disable iff (!resetn_i)
      cycle_strobe_o && four |=> !cycle_strobe_o [*3] ##1 cycle_strobe_o;
  endproperty
  a_four_clk: assert property (p_four_clk) else $error("four clock cycle");

  property p_two_clk;
    @(posedge clk_i) disable iff (!resetn_i)
      cycle_strobe_o && !four |=> !cycle_strobe_o ##1 cycle_strobe_o;
  endproperty
  a_two_clk: assert property (p_two_clk) else $error("two clock cycle");

  property p_protect;
    @(posedge clk_i) disable iff (!resetn_i)
      $past(resetn_i) |-> code_protect_o == !$past(cfg[`OWCT_B_PROT_N]);
  endproperty
  a_protect: assert property (p_protect) else $error("protect level wrong");

  property p_xtal_range;
    @(posedge clk_i) disable iff (!resetn_i)
      (high_crystal_mode_o || low_crystal_mode_o) |-> osc_is_xtal_o;
  endproperty
  a_xtal_range: assert property (p_xtal_range) else $error("crystal range in rc");

  property p_sdi50;
    @(posedge clk_i) disable iff (!resetn_i)
      $past(resetn_i, 4) && dly_sel == 2'h1 |-> serial_data_dly_o == $past(sdi_filt, 3);
  endproperty
  a_sdi50: assert property (p_sdi50) else $error("50 ns delay wrong");

  property p_sdi100;
    @(posedge clk_i) disable iff (!resetn_i)
      $past(resetn_i, 6) && dly_sel == 2'h2 |-> serial_data_dly_o == $past(sdi_filt, 5);
  endproperty
  a_sdi100: assert property (p_sdi100) else $error("100 ns delay wrong");

  // first cycle ends either in done or in the second cycle, never both
  property p_one_cycle;
    @(posedge clk_i) disable iff (!resetn_i)
      instr_accept_o && !four_clk_cycle_o |-> ##2 (instr_done_o ^ two_cycle_o);
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("two clock first cycle end");

  property p_one_cycle4;
    @(posedge clk_i) disable iff (!resetn_i)
      instr_accept_o && four_clk_cycle_o |-> ##4 (instr_done_o ^ two_cycle_o);
  endproperty
  a_one_cycle4: assert property (p_one_cycle4) else $error("four clock first cycle end");

  property p_two_cycle;
    @(posedge clk_i) disable iff (!resetn_i)
      two_cycle_o && !$past(two_cycle_o) |-> !instr_done_o ##[1:4] instr_done_o;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("second cycle lost");

  // op and mask of the write edge; a new take may already have replaced them
  property p_bit_set;
    @(posedge clk_i) disable iff (!resetn_i)
      reg_we_o && $past(bop) == BOP_SET |-> (reg_wdata_o & $past(mask)) == $past(mask);
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit not set");

  property p_bit_clr;
    @(posedge clk_i) disable iff (!resetn_i)
      reg_we_o && $past(bop) == BOP_CLR |-> (reg_wdata_o & $past(mask)) == 8'h00;
  endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("bit not cleared");
endmodule
`default_nettype wire

//--- rtl/owct_pkg.sv
// shared types of the option word and cycle timing block
package owct_pkg;
  typedef enum logic [1:0] {BOP_NONE, BOP_SET, BOP_CLR, BOP_TEST} owct_bitop_t;
  typedef enum logic [1:0] {EX_IDLE, EX_ONE, EX_TWO} owct_exec_t;
endpackage

//--- verif/owct_prog_model.sv
// programmer model: presents the option word written into the device
`timescale 1ns/100ps
`default_nettype none
module owct_prog_model (
  input wire logic [12:0] want_i,
  input wire logic break_i,
  output logic [12:0] cfg_word_o
);
  // rc words get the crystal range bit cleared; break_i leaves it set on purpose
  always_comb begin
    cfg_word_o = want_i;
    if (!want_i[12] && !break_i) begin
      cfg_word_o[8] = 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the option word loader and cycle timing core
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import owct_pkg::*;
  typedef struct packed {
    logic [12:0] cfg;
    logic brk;
    logic [14:0] opts;
    logic conf;
  } owct_cfg_row_t;
  typedef struct packed {
    logic [12:0] ins;
    logic flow;
    logic skip;
    owct_bitop_t bop;
    logic [1:0] cyc;
  } owct_ins_row_t;
  logic clk_i, resetn_i, instr_valid_i, flow_change_i, skip_true_i, serial_data_in_i, brk;
  logic [12:0] want, cfg_word, instr_i;
  logic [7:0] reg_rdata_i, rsp_i, reg_addr_o, reg_wdata_o, lit8_o;
  owct_bitop_t bit_op_i;
  logic osc_is_xtal_o, osc_ext_rc_o, osc_int_c_ext_r_o, high_crystal_mode_o, low_crystal_mode_o;
  logic osc_high_power_o, wdt_enable_o, four_clk_cycle_o, code_protect_o, cfg_conflict_o;
  logic cycle_strobe_o, instr_accept_o, instr_done_o, two_cycle_o, reg_is_io_o, reg_we_o;
  logic bit_test_o, serial_data_dly_o;
  logic [1:0] sdi_delay_sel_o;
  logic [3:0] user_id_o;
  logic [9:0] lit10_o;
  int num_errors = 0;
  int compares = 0;
  int base, lat, strobes;
  wire [14:0] opts_seen = {osc_is_xtal_o, osc_ext_rc_o, osc_int_c_ext_r_o, high_crystal_mode_o,
    low_crystal_mode_o, osc_high_power_o, wdt_enable_o, four_clk_cycle_o, code_protect_o,
    sdi_delay_sel_o, user_id_o};
  // ----------------------------------------
  // stimulus tables
  // ----------------------------------------
  // option word, misbehave flag, decoded options, conflict flag
  owct_cfg_row_t cfg_rows [7] = '{
    '{13'h1FFF, 1'b0, 15'h4ABF, 1'b0},
    '{13'h0000, 1'b0, 15'h1140, 1'b0},
    '{13'h0BE5, 1'b0, 15'h2215, 1'b0},
    '{13'h141A, 1'b0, 15'h45EA, 1'b0},
    '{13'h0100, 1'b1, 15'h1140, 1'b1},
    '{13'h1040, 1'b0, 15'h4340, 1'b1},
    '{13'h191C, 1'b0, 15'h486C, 1'b0}};
  // plain op, pc write, table add, return, interrupt return, flow change, taken skip, set,
  // clear, test of a clear bit
  owct_ins_row_t ins_rows [10] = '{
    '{13'h0000, 1'b0, 1'b0, BOP_NONE, 2'h1},
    '{13'h0042, 1'b0, 1'b0, BOP_NONE, 2'h2},
    '{13'h0020, 1'b0, 1'b0, BOP_NONE, 2'h2},
    '{13'h0012, 1'b0, 1'b0, BOP_NONE, 2'h2},
    '{13'h0013, 1'b0, 1'b0, BOP_NONE, 2'h2},
    '{13'h0000, 1'b1, 1'b0, BOP_NONE, 2'h2},
    '{13'h10D5, 1'b0, 1'b1, BOP_TEST, 2'h2},
    '{13'h10D5, 1'b0, 1'b0, BOP_SET, 2'h1},
    '{13'h10D5, 1'b0, 1'b0, BOP_CLR, 2'h1},
    '{13'h1015, 1'b0, 1'b0, BOP_TEST, 2'h1}};
  owct_prog_model prog_u (.want_i(want), .break_i(brk), .cfg_word_o(cfg_word));
  owct_option_timing dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .cfg_word_i(cfg_word),
    .instr_i(instr_i), .instr_valid_i(instr_valid_i), .flow_change_i(flow_change_i),
    .skip_true_i(skip_true_i), .bit_op_i(bit_op_i), .reg_rdata_i(reg_rdata_i), .rsp_i(rsp_i),
    .serial_data_in_i(serial_data_in_i), .osc_is_xtal_o(osc_is_xtal_o),
    .osc_ext_rc_o(osc_ext_rc_o), .osc_int_c_ext_r_o(osc_int_c_ext_r_o),
    .high_crystal_mode_o(high_crystal_mode_o), .low_crystal_mode_o(low_crystal_mode_o),
    .osc_high_power_o(osc_high_power_o), .wdt_enable_o(wdt_enable_o),
    .four_clk_cycle_o(four_clk_cycle_o), .code_protect_o(code_protect_o),
    .sdi_delay_sel_o(sdi_delay_sel_o), .user_id_o(user_id_o), .cfg_conflict_o(cfg_conflict_o),
    .cycle_strobe_o(cycle_strobe_o), .instr_accept_o(instr_accept_o),
    .instr_done_o(instr_done_o), .two_cycle_o(two_cycle_o), .reg_addr_o(reg_addr_o),
    .reg_is_io_o(reg_is_io_o), .reg_we_o(reg_we_o), .reg_wdata_o(reg_wdata_o),
    .bit_test_o(bit_test_o), .lit8_o(lit8_o), .lit10_o(lit10_o),
    .serial_data_dly_o(serial_data_dly_o));
  // 25 ns clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // 50 ns is two clocks, 100 ns four; code 00 read as no delay
  function automatic int dly_cyc(input logic [12:0] w);
    return ({w[4], w[5]} == 2'b01) ? 2 : ({w[4], w[5]} == 2'b10) ? 4 : 0;
  endfunction
  // reset with a word loaded, then show the inverse word to prove it is ignored
  task automatic do_reset(input owct_cfg_row_t r);
    @(negedge clk_i);
    resetn_i = 1'b0;
    want = r.cfg;
    brk = r.brk;
    repeat (10) @(negedge clk_i);
    resetn_i = 1'b1;
    want = ~r.cfg;
    brk = 1'b0;
  endtask
  // one instruction: hold valid until accepted, then count clocks to done
  task automatic run_ins(input owct_ins_row_t r, input logic [1:0] bank, input int cycle_clocks_sel);
    int n;
    int tc;
    n = 0;
    tc = 0;
    @(negedge clk_i);
    instr_i = r.ins;
    instr_valid_i = 1'b1;
    flow_change_i = r.flow;
    skip_true_i = r.skip;
    bit_op_i = r.bop;
    rsp_i = {bank, 6'h2A};
    reg_rdata_i = (r.bop == BOP_SET) ? 8'hA1 : 8'h5E;
    while (instr_accept_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("accept", 16'(instr_accept_o), 16'h0001);
    chk("reg addr", 16'(reg_addr_o), 16'({bank, r.ins[5:0]}));
    chk("io reg", 16'(reg_is_io_o), 16'(r.ins[5:0] <= 6'h0F));
    chk("lit8", 16'(lit8_o), 16'(r.ins[7:0]));
    chk("lit10", 16'(lit10_o), 16'(r.ins[9:0]));
    n = 0;
    @(negedge clk_i);
    instr_valid_i = 1'b0;
    while (instr_done_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
      if (two_cycle_o === 1'b1) tc++;
    end
    chk("cycle clocks", 16'(n), 16'(r.cyc * cycle_clocks_sel));
    chk("second cycle", 16'(tc), 16'((r.cyc - 2'h1) * cycle_clocks_sel));
    chk("write strobe", 16'(reg_we_o), 16'(r.bop inside {BOP_SET, BOP_CLR}));
    if (r.bop == BOP_SET) chk("set data", 16'(reg_wdata_o), 16'h00A9);
    if (r.bop == BOP_CLR) chk("clear data", 16'(reg_wdata_o), 16'h0056);
    if (r.bop == BOP_TEST) chk("bit test", 16'(bit_test_o), 16'(reg_rdata_i[r.ins[8:6]]));
  endtask
  // watchdog: the run needs about 740 clocks, the limit is 8000
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn_i = 1'b0;
    want = 13'h1FFF;
    brk = 1'b0;
    instr_i = 13'h0000;
    instr_valid_i = 1'b0;
    flow_change_i = 1'b0;
    skip_true_i = 1'b0;
    bit_op_i = BOP_NONE;
    reg_rdata_i = 8'h00;
    rsp_i = 8'h00;
    serial_data_in_i = 1'b0;
    base = 0;
    foreach (cfg_rows[i]) begin
      do_reset(cfg_rows[i]);
      repeat (3) @(negedge clk_i);
      chk("options", 16'(opts_seen), 16'(cfg_rows[i].opts));
      chk("conflict", 16'(cfg_conflict_o), 16'(cfg_rows[i].conf));
      strobes = 0;
      repeat (16) begin
        @(posedge clk_i);
        #1;
        if (cycle_strobe_o === 1'b1) strobes++;
      end
      chk("strobes", 16'(strobes), cfg_rows[i].cfg[10] ? 16'h0004 : 16'h0008);
      // serial delay measured against the no-delay word of the first row
      @(negedge clk_i);
      serial_data_in_i = 1'b1;
      lat = 0;
      while (serial_data_dly_o !== 1'b1 && lat < 40) begin
        @(posedge clk_i);
        #1;
        lat++;
      end
      if (i == 0) base = lat;
      chk("sdi delay", 16'(lat), 16'(base + dly_cyc(cfg_rows[i].cfg)));
      @(negedge clk_i);
      serial_data_in_i = 1'b0;
      foreach (ins_rows[j]) run_ins(ins_rows[j], 2'(j), cfg_rows[i].cfg[10] ? 4 : 2);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
